//--- rtl/drive_io_supervisor_defs.svh
`ifndef DRIVE_IO_SUPERVISOR_DEFS_SVH
`define DRIVE_IO_SUPERVISOR_DEFS_SVH

`define CLK_FREQ_HZ            100000000
`define RELAY_SEL_DEFAULT      3'h2
`define RELAY_BIT_UNDERVOLT    0
`define RELAY_BIT_GENERAL      1
`define RELAY_BIT_RETRY        2
`define STATION_ID_DEFAULT     8'h01
`define BAUD_CODE_DEFAULT      3'h3
`define LINK_TIMEOUT_DS_DEF    8'h0a
`define LINK_ACTION_DEFAULT    2'h0
`define LINK_ACTION_KEEP       2'h0
`define LINK_ACTION_CUTOFF     2'h1
`define LINK_ACTION_DECEL      2'h2
`define SOURCE_SERIAL_LINK     3'h4
`define TURNAROUND_MS_DEFAULT  8'h05
`define POLARITY_DEFAULT       11'h000
`define EXPANSION_MASK         11'h700
`define CHECK_TIME_MS_DEFAULT  8'h01
`define OVERHEAT_SEL_DEFAULT   3'h7
`define OVERHEAT_BIT_MOTOR     0
`define OVERHEAT_BIT_EXTERNAL  2
`define TRIP_TEMP_DEFAULT      8'h6e
`define TICK_MS_US             1000
`define TICK_MS_CYCLES         ((`CLK_FREQ_HZ / 1000000) * `TICK_MS_US)
`define TICK_CNT_W             17
`define INPUT_COUNT            11

`endif

//--- rtl/drive_io_supervisor_pkg.sv
`default_nettype none
package drive_io_supervisor_pkg;

  typedef enum logic [1:0] {
    ACT_RUN,
    ACT_CUTOFF,
    ACT_DECEL
  } link_action_e;

  typedef struct packed {
    logic undervoltage;
    logic drive_disable;
    logic general;
    logic retry_exhausted;
    logic retry_active;
  } fault_s;

  typedef struct packed {
    logic [7:0] station_id;
    logic [2:0] baud_code;
    logic [7:0] timeout_ds;
    logic [1:0] loss_action;
    logic [7:0] turnaround_ms;
    logic [2:0] run_source;
    logic [2:0] freq_source;
  } link_cfg_s;

  typedef struct packed {
    logic       frame_valid;
    logic [7:0] frame_station;
  } link_rx_s;

  typedef struct packed {
    logic       link_loss_indicator;
    logic       coast_output_cutoff;
    logic       decel_stop_request;
    logic       answer_enable;
    logic       turnaround_done;
  } link_stat_s;

endpackage
`default_nettype wire

//--- rtl/input_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_supervisor_defs.svh"

// Polarity-corrected input qualification for one terminal
module input_qualifier (
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  input  wire logic       ms_tick_in,
  input  wire logic       qualify_in,
  input  wire logic [7:0] check_ms_in,
  input  wire logic       level_in,
  output logic            level_out
);
  typedef struct packed {
    logic       held;
    logic       out;
    logic [7:0] count;
  } qual_state_s;

  qual_state_s state_reg;
  qual_state_s state_next;

  // Restart count on any change; accept once stable for the check time
  always_comb begin
    state_next = state_reg;
    if (!qualify_in) begin
      state_next.out = level_in;   // see RL14
      state_next.held = level_in;
      state_next.count = 8'h00;
    end else if (level_in != state_reg.held) begin
      state_next.held = level_in;
      state_next.count = 8'h00;
    end else if (state_reg.out != state_reg.held) begin
      // Count saturates so a long check time cannot wrap back to zero
      if (ms_tick_in && state_reg.count != 8'hff) begin
        state_next.count = state_reg.count + 8'h01;
      end
      // First tick is partial, so one extra tick guarantees the full time
      if (state_reg.count > check_ms_in || state_reg.count == 8'hff) begin
        state_next.out = state_reg.held;   // see RL14
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.out;
endmodule
`default_nettype wire

//--- rtl/drive_io_supervisor.sv
//Contract
// RL1 - Three-bit relay select, default general fault only
// RL2 - Undervoltage energises relay when its bit set
// RL3 - General bit: all faults except undervoltage, disable
// RL4 - Retry bit: relay only when retries exhausted
// RL5 - Priority: undervoltage, then general, then retry
// RL6 - Station id default one; answer own frames
// RL7 - Baud code default three means 9600
// RL8 - Link lost when no frame within timeout
// RL9 - Loss action: keep, cut off, decelerate
// RL10 - Loss logic only when source is serial
// RL11 - Turnaround delay, default 5 ms
// RL12 - Eleven polarity bits, one selects normally closed
// RL13 - Expansion polarity only with sub-board fitted
// RL14 - Multi-step inputs qualified by checking time
// RL15 - Overheat select default 111, bit two reserved; here bit two drives external_sensor_out
// RL16 - Motor trip at configured temperature, default 110
// RL17 - Heat-sink overheat protection always active
// RL18 - Polarity applied before qualification timing
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_supervisor_defs.svh"

module drive_io_supervisor
  import drive_io_supervisor_pkg::*;
(
  input  wire logic                        clock_in,
  input  wire logic                        srst_in,
  input  wire logic [2:0]                  relay_select_in,
  input  wire logic                        relay_select_load_in,
  input  wire drive_io_supervisor_pkg::fault_s    faults_in,
  input  wire drive_io_supervisor_pkg::link_cfg_s link_cfg_in,
  input  wire logic                        link_cfg_load_in,
  input  wire drive_io_supervisor_pkg::link_rx_s  link_rx_in,
  input  wire logic                        tx_request_in,
  input  wire logic [10:0]                 polarity_in,
  input  wire logic                        polarity_load_in,
  input  wire logic                        expansion_fitted_in,
  input  wire logic                        multi_step_active_in,
  input  wire logic [7:0]                  check_ms_in,
  input  wire logic                        check_ms_load_in,
  input  wire logic [10:0]                 raw_inputs_in,
  input  wire logic [2:0]                  overheat_select_in,
  input  wire logic [7:0]                  trip_temp_in,
  input  wire logic                        overheat_cfg_load_in,
  input  wire logic [7:0]                  motor_temp_in,
  input  wire logic                        heatsink_hot_in,
  output logic                             relay_open_contact_out,
  output logic                             relay_closed_contact_out,
  output logic [2:0]                       relay_select_out,
  output drive_io_supervisor_pkg::link_cfg_s      link_cfg_out,
  output drive_io_supervisor_pkg::link_stat_s     link_stat_out,
  output logic [10:0]                      inputs_out,
  output logic                             motor_overheat_trip_out,
  output logic                             external_sensor_out,
  output logic                             heatsink_trip_out
);
  import drive_io_supervisor_pkg::*;

  typedef struct packed {
    logic [2:0]            relay_sel;
    logic                  relay_on;
    logic                  relay_off;
    link_cfg_s             cfg;
    link_stat_s            stat;
    logic [`TICK_CNT_W-1:0] tick_cnt;
    logic                  ms_tick;
    logic [6:0]            ds_cnt;
    logic [15:0]           idle_ms;
    logic [7:0]            turn_cnt;
    logic                  turn_busy;
    logic [10:0]           polarity;
    logic [7:0]            check_ms;
    logic [2:0]            oh_sel;
    logic [7:0]            trip_temp;
    logic                  motor_trip;
    logic                  hs_trip;
    logic [10:0]           inputs;
  } sup_state_s;

  sup_state_s state_reg;
  sup_state_s state_next;
  logic [10:0] corrected;
  logic [10:0] qualified;

  // Link source selects the serial link on either command path
  function automatic logic link_in_use(input link_cfg_s c);
    link_in_use = (c.run_source == `SOURCE_SERIAL_LINK) ||
                  (c.freq_source == `SOURCE_SERIAL_LINK);
  endfunction

  function automatic sup_state_s reset_state();
    sup_state_s s;
    s = '0;
    s.relay_sel = `RELAY_SEL_DEFAULT;            // see RL1
    s.relay_off = 1'b1;
    s.cfg.station_id = `STATION_ID_DEFAULT;      // see RL6
    s.cfg.baud_code = `BAUD_CODE_DEFAULT;        // see RL7
    s.cfg.timeout_ds = `LINK_TIMEOUT_DS_DEF;     // see RL8
    s.cfg.loss_action = `LINK_ACTION_DEFAULT;
    s.cfg.turnaround_ms = `TURNAROUND_MS_DEFAULT; // see RL11
    s.polarity = `POLARITY_DEFAULT;
    s.check_ms = `CHECK_TIME_MS_DEFAULT;
    s.oh_sel = `OVERHEAT_SEL_DEFAULT;            // see RL15
    s.trip_temp = `TRIP_TEMP_DEFAULT;            // see RL16
    s.stat.turnaround_done = 1'b0;
    reset_state = s;
  endfunction

  // Polarity inversion ahead of qualification; expansion gated by board
  // Without the sub-board the expansion pins float, so their polarity
  // bits are ignored rather than trusted to stay cleared by software
  always_comb begin
    logic [10:0] pol_eff;
    pol_eff = state_reg.polarity;
    if (!expansion_fitted_in) begin
      pol_eff = state_reg.polarity & ~(`EXPANSION_MASK); // see RL13
    end
    corrected = raw_inputs_in ^ pol_eff;   // see RL12 see RL18
  end

  // One qualifier per terminal, all sharing the millisecond tick
  // Sharing one divider keeps the terminals in step; the cost is that
  // the first tick after a change is partial for every terminal
  genvar gi;
  generate
    for (gi = 0; gi < `INPUT_COUNT; gi++) begin : g_qual
      input_qualifier u_qual (
        .clock_in    (clock_in),
        .srst_in     (srst_in),
        .ms_tick_in  (state_reg.ms_tick),
        .qualify_in  (multi_step_active_in),
        .check_ms_in (state_reg.check_ms),
        .level_in    (corrected[gi]),
        .level_out   (qualified[gi])
      );
    end
  endgenerate

  // Next-state for configuration, relay, link and overheat logic
  always_comb begin
    logic       own_frame;
    logic       relay_want;
    logic [15:0] limit_ms;
    own_frame = 1'b0;
    relay_want = 1'b0;
    limit_ms = 16'h0000;
    state_next = state_reg;

    // Configuration loads
    if (relay_select_load_in) begin
      state_next.relay_sel = relay_select_in;
    end
    if (link_cfg_load_in) begin
      state_next.cfg = link_cfg_in;
    end
    if (polarity_load_in) begin
      state_next.polarity = polarity_in;
    end
    if (check_ms_load_in) begin
      state_next.check_ms = check_ms_in;
    end
    if (overheat_cfg_load_in) begin
      state_next.oh_sel = overheat_select_in;
      state_next.trip_temp = trip_temp_in;
    end

    // Millisecond tick divider
    // Free running from reset; all slow timers use this one-cycle pulse
    // instead of a second clock, so there is no domain crossing
    state_next.ms_tick = 1'b0;
    if (state_reg.tick_cnt == `TICK_CNT_W'(`TICK_MS_CYCLES - 1)) begin
      state_next.tick_cnt = '0;
      state_next.ms_tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + `TICK_CNT_W'(1);
    end

    // Relay classes evaluated in fixed priority order
    // The relay follows fault levels and is not latched; a caller that
    // wants a sticky trip must hold the fault level itself
    // Drive-disable only masks the general class, never undervoltage
    if (state_reg.relay_sel[`RELAY_BIT_UNDERVOLT] &&
        faults_in.undervoltage) begin
      relay_want = 1'b1;                          // see RL2 see RL5
    end else if (state_reg.relay_sel[`RELAY_BIT_GENERAL] &&
                 faults_in.general && !faults_in.drive_disable) begin
      relay_want = 1'b1;                          // see RL3 see RL5
    end else if (state_reg.relay_sel[`RELAY_BIT_RETRY] &&
                 faults_in.retry_exhausted &&
                 !faults_in.retry_active) begin
      relay_want = 1'b1;                          // see RL4 see RL5
    end
    state_next.relay_on = relay_want;
    // Both contacts come from their own flops so they never glitch apart
    state_next.relay_off = !relay_want;

    // Station match gates replies
    own_frame = link_rx_in.frame_valid &&
                (link_rx_in.frame_station == state_reg.cfg.station_id);
    state_next.stat.answer_enable = own_frame;    // see RL6

    // Loss timer counts in milliseconds, timeout in tenths of seconds
    // A zero timeout declares loss at the first tick; the indicator
    // then holds until an own frame arrives or the source changes
    // Counting stops once lost, so the timer cannot wrap and re-fire
    limit_ms = 16'(state_reg.cfg.timeout_ds) * 16'd100;
    if (!link_in_use(state_reg.cfg) || own_frame) begin
      state_next.idle_ms = '0;                    // see RL10
      state_next.stat.link_loss_indicator = 1'b0;
    end else if (state_reg.ms_tick &&
                 !state_reg.stat.link_loss_indicator) begin
      state_next.idle_ms = state_reg.idle_ms + 16'h0001;
      if (state_reg.idle_ms + 16'h0001 >= limit_ms) begin
        state_next.stat.link_loss_indicator = 1'b1; // see RL8
      end
    end

    // Loss action applies only while lost
    state_next.stat.coast_output_cutoff = 1'b0;
    state_next.stat.decel_stop_request = 1'b0;
    if (state_reg.stat.link_loss_indicator) begin
      case (state_reg.cfg.loss_action)
        `LINK_ACTION_CUTOFF: state_next.stat.coast_output_cutoff = 1'b1;
        `LINK_ACTION_DECEL:  state_next.stat.decel_stop_request = 1'b1;
        default: ;                                // see RL9
      endcase
    end

    // Turnaround delay before a reply may go out
    // Requests while busy are dropped; a zero setting acts as one tick
    // so a reply can never collide with the tail of the host frame
    state_next.stat.turnaround_done = 1'b0;
    if (tx_request_in && !state_reg.turn_busy) begin
      state_next.turn_busy = 1'b1;
      state_next.turn_cnt = '0;
    end else if (state_reg.turn_busy && state_reg.ms_tick) begin
      if (state_reg.turn_cnt + 8'h01 >= state_reg.cfg.turnaround_ms) begin
        state_next.turn_busy = 1'b0;
        state_next.stat.turnaround_done = 1'b1;   // see RL11
      end else begin
        state_next.turn_cnt = state_reg.turn_cnt + 8'h01;
      end
    end

    // Overheat protection
    // Heat-sink trip has no enable bit at all: it must not be possible
    // to switch off the power stage protection from configuration
    state_next.motor_trip = state_reg.oh_sel[`OVERHEAT_BIT_MOTOR] &&
                            (motor_temp_in >= state_reg.trip_temp); // see RL16
    state_next.hs_trip = heatsink_hot_in;         // see RL17
    state_next.inputs = qualified;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  // Registered outputs; closed contact has its own inverse flop
  assign relay_open_contact_out   = state_reg.relay_on;
  assign relay_closed_contact_out = state_reg.relay_off;
  assign relay_select_out         = state_reg.relay_sel;
  assign link_cfg_out             = state_reg.cfg;
  assign link_stat_out            = state_reg.stat;
  assign inputs_out               = state_reg.inputs;
  assign motor_overheat_trip_out  = state_reg.motor_trip;
  assign external_sensor_out      = state_reg.oh_sel[`OVERHEAT_BIT_EXTERNAL];
  assign heatsink_trip_out        = state_reg.hs_trip;
endmodule
`default_nettype wire

//--- tb/drive_io_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Relay classes, config echo, station match and heat-sink trip
module drive_io_supervisor_properties
  import drive_io_supervisor_pkg::*;
(
  input  wire logic                           clock_in,
  input  wire logic                           srst_in,
  input  wire logic [2:0]                     relay_select_in,
  input  wire logic                           relay_select_load_in,
  input  wire drive_io_supervisor_pkg::fault_s    faults_in,
  input  wire drive_io_supervisor_pkg::link_cfg_s link_cfg_in,
  input  wire logic                           link_cfg_load_in,
  input  wire drive_io_supervisor_pkg::link_rx_s  link_rx_in,
  input  wire logic                           heatsink_hot_in,
  input  wire logic                           relay_open_contact_out,
  input  wire logic                           relay_closed_contact_out,
  input  wire logic [2:0]                     relay_select_out,
  input  wire drive_io_supervisor_pkg::link_cfg_s link_cfg_out,
  input  wire drive_io_supervisor_pkg::link_stat_s link_stat_out,
  input  wire logic                           heatsink_trip_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Classes that the present faults call for, under the held selection
  wire logic uv_hit  = relay_select_out[0] && faults_in.undervoltage;
  wire logic gen_hit = relay_select_out[1] && faults_in.general
                       && !faults_in.drive_disable;
  wire logic rty_hit = relay_select_out[2] && faults_in.retry_exhausted
                       && !faults_in.retry_active;
  sequence s_own;
    link_rx_in.frame_valid
      && link_rx_in.frame_station == link_cfg_out.station_id;
  endsequence
  sequence s_foreign;
    !(link_rx_in.frame_valid
      && link_rx_in.frame_station == link_cfg_out.station_id);
  endsequence
  property p_uv; uv_hit |=> relay_open_contact_out; endproperty
  a_uv: assert property (p_uv) else $error("relay idle on undervoltage");
  property p_gen; gen_hit |=> relay_open_contact_out; endproperty
  a_gen: assert property (p_gen) else $error("relay idle on fault");
  property p_rty; rty_hit |=> relay_open_contact_out; endproperty
  a_rty: assert property (p_rty) else $error("relay idle on retry");
  property p_none;
    !(uv_hit || gen_hit || rty_hit) |=> !relay_open_contact_out;
  endproperty
  a_none: assert property (p_none) else $error("relay without cause");
  property p_contacts; relay_closed_contact_out != relay_open_contact_out;
  endproperty
  a_contacts: assert property (p_contacts) else $error("contacts agree");
  property p_sel;
    relay_select_load_in |=> relay_select_out == $past(relay_select_in);
  endproperty
  a_sel: assert property (p_sel) else $error("relay select not held");
  property p_cfg;
    link_cfg_load_in |=> link_cfg_out == $past(link_cfg_in);
  endproperty
  a_cfg: assert property (p_cfg) else $error("link config not held");
  property p_own; s_own |=> link_stat_out.answer_enable; endproperty
  a_own: assert property (p_own) else $error("own frame unanswered");
  property p_foreign; s_foreign |=> !link_stat_out.answer_enable;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign answered");
  property p_cut;
    link_stat_out.link_loss_indicator && link_cfg_out.loss_action == 2'h1
      |=> link_stat_out.coast_output_cutoff;
  endproperty
  a_cut: assert property (p_cut) else $error("no cutoff on loss");
  property p_heat; heatsink_hot_in |=> heatsink_trip_out; endproperty
  a_heat: assert property (p_heat) else $error("heat sink not tripped");
endmodule
bind drive_io_supervisor drive_io_supervisor_properties u_props (
  .clock_in, .srst_in, .relay_select_in, .relay_select_load_in, .faults_in,
  .link_cfg_in, .link_cfg_load_in, .link_rx_in, .heatsink_hot_in,
  .relay_open_contact_out, .relay_closed_contact_out, .relay_select_out,
  .link_cfg_out, .link_stat_out, .heatsink_trip_out);
`default_nettype wire

//--- tb/link_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the serial link: one addressed frame per send, after a gap
module link_host_model
  import drive_io_supervisor_pkg::*;
(
  input  wire logic                          clock_in,
  input  wire logic                          srst_in,
  input  wire logic                          send_in,
  input  wire logic [7:0]                    station_in,
  input  wire logic [3:0]                    gap_in,
  output drive_io_supervisor_pkg::link_rx_s  rx_out
);
  logic [3:0] gap_reg;
  logic       busy_reg;
  logic [7:0] station_reg;
  // Idle address is inverted each cycle so a stale match never lingers
  always_ff @(posedge clock_in) begin
    rx_out.frame_valid <= 1'b0;
    rx_out.frame_station <= ~rx_out.frame_station;
    if (srst_in) begin
      rx_out <= '0;
      busy_reg <= 1'b0;
    end else if (send_in) begin
      busy_reg <= 1'b1;
      gap_reg <= gap_in;
      station_reg <= station_in;
    end else if (busy_reg && gap_reg != 4'h0) begin
      gap_reg <= gap_reg - 4'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      rx_out <= {1'b1, station_reg};
    end
  end
endmodule
`default_nettype wire

//--- tb/drive_io_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drive_io_supervisor_tb;
  import drive_io_supervisor_pkg::*;
  logic clock_in = 1'b0, srst_in = 1'b1, sel_ld, cfg_ld, tx_req, pol_ld;
  logic fit, multi, chk_ld, oh_ld, hot, rl_open, rl_closed, mot, ext, hs;
  logic send;
  logic [2:0] sel, sel_o, oh_sel;
  logic [3:0] gap;
  logic [7:0] chk_ms, trip, temp, host_st;
  logic [10:0] pol, raw, ins_o;
  fault_s faults;
  link_cfg_s cfg, cfg_o;
  link_rx_s rx;
  link_stat_s stat;
  int err_count, checked, seed = 89, i, n;
  drive_io_supervisor dut (.clock_in, .srst_in, .relay_select_in(sel),
    .relay_select_load_in(sel_ld), .faults_in(faults), .link_cfg_in(cfg),
    .link_cfg_load_in(cfg_ld), .link_rx_in(rx), .tx_request_in(tx_req),
    .polarity_in(pol), .polarity_load_in(pol_ld), .expansion_fitted_in(fit),
    .multi_step_active_in(multi), .check_ms_in(chk_ms),
    .check_ms_load_in(chk_ld), .raw_inputs_in(raw),
    .overheat_select_in(oh_sel), .trip_temp_in(trip),
    .overheat_cfg_load_in(oh_ld), .motor_temp_in(temp),
    .heatsink_hot_in(hot), .relay_open_contact_out(rl_open),
    .relay_closed_contact_out(rl_closed), .relay_select_out(sel_o),
    .link_cfg_out(cfg_o), .link_stat_out(stat), .inputs_out(ins_o),
    .motor_overheat_trip_out(mot), .external_sensor_out(ext),
    .heatsink_trip_out(hs));
  link_host_model host (.clock_in, .srst_in, .send_in(send),
    .station_in(host_st), .gap_in(gap), .rx_out(rx));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  task tick(input int k);
    repeat (k) @(negedge clock_in);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task close_out;
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Relay classes in priority order; select bit 0 undervoltage, 1 general, 2 retry
  function logic exp_relay(input logic [2:0] s, input fault_s f);
    return (s[0] && f.undervoltage)
      || (s[1] && f.general && !f.drive_disable)
      || (s[2] && f.retry_exhausted && !f.retry_active);
  endfunction
  // Expansion polarity bits count only with the sub-board fitted
  function logic [10:0] exp_in(input logic [10:0] r, p, input logic f);
    return r ^ (f ? p : (p & 11'h0ff));
  endfunction
  // Host frame, then count answers within a bounded window
  task frame(input logic [7:0] st, input logic [3:0] g, input int e);
    host_st = st;
    gap = g;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    n = 0;
    repeat (30) begin
      tick(1);
      if (stat.answer_enable === 1'b1) n++;
    end
    chk("answer_count", e, n);
  endtask
  // Main sequence: defaults, relay, link, inputs, overheat, turnaround
  initial begin
    {sel, sel_ld, faults, cfg, cfg_ld, tx_req, pol, pol_ld, fit, multi} = '0;
    {chk_ms, chk_ld, raw, oh_sel, trip, oh_ld, temp, hot} = '0;
    {send, host_st, gap} = '0;
    tick(5);
    srst_in = 1'b0;
    tick(1);
    chk("relay_select", 3'h2, sel_o);
    chk("station", 8'h01, cfg_o.station_id);
    chk("baud", 3'h3, cfg_o.baud_code);
    chk("timeout", 8'h0a, cfg_o.timeout_ds);
    chk("turnaround", 8'h05, cfg_o.turnaround_ms);
    chk("ext_sensor", 1'b1, ext);
    for (i = 0; i < 200; i++) begin
      sel = (i < 8) ? i[2:0] : 3'($random(seed));
      faults = (i < 8) ? 5'h16 : 5'($random(seed));
      sel_ld = 1'b1;
      tick(1);
      sel_ld = 1'b0;
      tick(1);
      chk("relay_open", exp_relay(sel, faults), rl_open);
    end
    cfg = {8'h05, 3'h3, 8'h0a, 2'h1, 8'h01, 3'h4, 3'h0};
    cfg_ld = 1'b1;
    tick(1);
    cfg_ld = 1'b0;
    frame(8'h05, 4'h0, 1);
    frame(8'h01, 4'h3, 0);
    frame(8'h05, 4'h9, 1);
    for (i = 0; i < 60; i++) begin
      pol = 11'($random(seed));
      raw = 11'($random(seed));
      fit = i[0];
      pol_ld = 1'b1;
      tick(1);
      pol_ld = 1'b0;
      tick(3);
      chk("inputs", exp_in(raw, pol, fit), ins_o);
    end
    multi = 1'b1;
    chk_ms = 8'h01;
    chk_ld = 1'b1;
    tick(1);
    chk_ld = 1'b0;
    raw = ~raw;
    tick(50);
    chk("inputs_held", exp_in(~raw, pol, fit), ins_o);
    for (i = 0; i < 40; i++) begin
      oh_sel = 3'($random(seed));
      trip = (i < 2) ? 8'h6e : 8'($random(seed));
      temp = (i == 0) ? 8'h6e : (i == 1) ? 8'h6d : 8'($random(seed));
      hot = 1'($random(seed));
      oh_ld = 1'b1;
      tick(1);
      oh_ld = 1'b0;
      tick(1);
      chk("motor_trip", oh_sel[0] && temp >= trip, mot);
      chk("ext_sensor", oh_sel[2], ext);
      chk("heatsink", hot, hs);
    end
    cfg = {8'h05, 3'h3, 8'h00, 2'h1, 8'h01, 3'h4, 3'h0};
    cfg_ld = 1'b1;
    tick(1);
    cfg_ld = 1'b0;
    tx_req = 1'b1;
    tick(1);
    tx_req = 1'b0;
    for (n = 0; n < 100010 && stat.turnaround_done !== 1'b1; n++) tick(1);
    chk("turnaround_done", 1'b1, stat.turnaround_done);
    chk("link_loss", 1'b1, stat.link_loss_indicator);
    tick(1);
    chk("cutoff", 1'b1, stat.coast_output_cutoff);
    chk("decel", 1'b0, stat.decel_stop_request);
    close_out();
  end
endmodule
`default_nettype wire
